// File: bench/tb_tmr_one_pulse.sv
// Testbench of the one-pulse timer over its register port and pins
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_tmr_one_pulse;
    import tmr_pkg::*;
    localparam logic [7:0] CMP = 8'h08;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic trig_req = 1'b0;
    logic capb_req = 1'b0;
    logic trigger_input_a;
    logic capture_input_b;
    logic pulse_output_a;
    logic pulse_output_a_oe;
    logic irq;
    int high_cycles;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] v;
    int w;

    always #12.5 clk = ~clk;

    tmr_one_pulse #(.SLOW_PRESCALE(16)) dut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .trigger_input_a(trigger_input_a),
        .capture_input_b(capture_input_b), .pulse_output_a(pulse_output_a),
        .pulse_output_a_oe(pulse_output_a_oe), .irq(irq));

    tmr_pin_model pins (.clk(clk), .trig_req(trig_req), .capb_req(capb_req),
        .pulse_output_a(pulse_output_a),
        .pulse_output_a_oe(pulse_output_a_oe),
        .trigger_input_a(trigger_input_a),
        .capture_input_b(capture_input_b), .high_cycles(high_cycles));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d, fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic wait_out(input logic lvl);
        int i;
        for (i = 0; i < 100 && pulse_output_a !== lvl; i++) @(negedge clk);
        if (pulse_output_a !== lvl) begin
            fail_count++;
            $display("unexpected at %0t: output level never came", $time);
            print_verdict();
        end
    endtask : wait_out

    task automatic hold_out(input logic lvl, input int n);
        repeat (n) begin
            @(negedge clk);
            `CHK(pulse_output_a, lvl)
        end
    endtask : hold_out

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_STATUS, v); `CHK(v, 8'h00)
        rd(ADDR_CTRL_TWO, v); `CHK(v, 8'h00)
        wr(8'h50, 8'hff);
        rd(8'h50, v); `CHK(v, 8'h00)
        // Divide by two so pulse widths stay short
        wr(ADDR_CMP_A, CMP);
        wr(ADDR_CTRL_ONE, 8'h86);
        wr(ADDR_CTRL_TWO, 8'ha0);
        @(negedge clk);
        `CHK(pulse_output_a_oe, 1'b1)
        `CHK(pulse_output_a, 1'b0)
        trig_req <= 1'b1;
        wait_out(1'b1);
        w = high_cycles;
        `CHK(irq, 1'b1)
        wait_out(1'b0);
        w = high_cycles - w + 1;
        `CHK(w >= 22 && w <= 26, 1'b1)
        rd(ADDR_CAP_A, v); `CHK(v, 8'hfd)
        `CHK(irq, 1'b1)
        rd(ADDR_STATUS, v); `CHK(v & 8'hc0, 8'h80)
        rd(ADDR_CAP_A, v);
        rd(ADDR_STATUS, v); `CHK(v & 8'h80, 8'h00)
        `CHK(irq, 1'b0)
        // Falling edge fires, rising edge is ignored
        wr(ADDR_CTRL_ONE, 8'h04);
        trig_req <= 1'b0;
        wait_out(1'b1);
        wait_out(1'b0);
        trig_req <= 1'b1;
        hold_out(1'b0, 30);
        // Equal levels keep the pin still across a trigger
        wr(ADDR_CTRL_ONE, 8'h02);
        trig_req <= 1'b0;
        repeat (8) @(posedge clk);
        trig_req <= 1'b1;
        hold_out(1'b0, 40);
        // Plain mode, then pwm over single-shot: no pulse either way
        wr(ADDR_CTRL_ONE, 8'h06);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL_TWO, k == 0 ? 8'h80 : 8'hb0);
            trig_req <= 1'b0;
            repeat (8) @(posedge clk);
            trig_req <= 1'b1;
            hold_out(1'b0, 30);
        end
        // Second input still captures in single-shot mode
        wr(ADDR_CTRL_ONE, 8'h00);
        wr(ADDR_CTRL_TWO, 8'ha2);
        capb_req <= 1'b1;
        repeat (12) @(posedge clk);
        rd(ADDR_STATUS, v); `CHK(v & 8'h10, 8'h10)
        hold_out(1'b0, 4);
        wr(ADDR_IRQ_ENABLE, 8'h02);
        @(negedge clk); `CHK(irq, 1'b1)
        wr(ADDR_IRQ_ENABLE, 8'h00);
        @(negedge clk); `CHK(irq, 1'b0)
        rd(ADDR_IRQ_STATUS, v); `CHK(v & 8'h02, 8'h02)
        wr(ADDR_IRQ_CLEAR, 8'h02);
        rd(ADDR_IRQ_STATUS, v); `CHK(v & 8'h02, 8'h00)
        // Slow prescale: four ticks from the preset to a zero compare
        wr(ADDR_CMP_A, 8'h00);
        wr(ADDR_CTRL_ONE, 8'h06);
        wr(ADDR_CTRL_TWO, 8'hac);
        trig_req <= 1'b0;
        repeat (8) @(posedge clk);
        trig_req <= 1'b1;
        wait_out(1'b1);
        w = high_cycles;
        wait_out(1'b0);
        w = high_cycles - w + 1;
        `CHK(w >= 64 && w <= 66, 1'b1)
        print_verdict();
    end
endmodule : tb_tmr_one_pulse

// File: bench/tmr_pin_model.sv
// Trigger source and pulse load that stand at the timer's pins
`timescale 1ns/10ps
module tmr_pin_model (
    input wire logic clk,
    input wire logic trig_req,
    input wire logic capb_req,
    input wire logic pulse_output_a,
    input wire logic pulse_output_a_oe,
    output logic trigger_input_a,
    output logic capture_input_b,
    output int high_cycles
);
    // ------------------------------------------------------------------
    // Source
    // ------------------------------------------------------------------
    // Pins move off the clock edge, as a real outside source would
    initial begin
        trigger_input_a = 1'b0;
        capture_input_b = 1'b0;
    end
    always @(trig_req) trigger_input_a <= #7 trig_req;
    always @(capb_req) capture_input_b <= #11 capb_req;
    // ------------------------------------------------------------------
    // Load
    // ------------------------------------------------------------------
    // Counts the driven-high cycles of all pulses so far, never cleared
    initial high_cycles = 0;
    always @(posedge clk) begin
        if (pulse_output_a_oe === 1'b1 && pulse_output_a === 1'b1) begin
            high_cycles <= high_cycles + 1;
        end
    end
endmodule : tmr_pin_model

// File: rtl/tmr_one_pulse.sv
// Eight-bit timer with one-pulse mode, capture and compare channels
// Summary of operation
// (R1) Pulse mode only while single-shot select set
// (R2) Trigger presets counter, drives pulse, captures marker
// (R3) Capture flag raises interrupt when enabled
// (R4) Flag clears: status read, then capture access
// (R5) Compare match drives after-pulse level
// (R6) Software computes compare value from pulse time
// (R7) Compare flag a never set in pulse mode
// (R8) PWM select overrides single-shot select
// (R9) Equal levels give constant output
// (R10) Input b still captures; input a restarts
// (R11) Compare b flags time, no waveform
// (R12) Edge select picks rising or falling trigger
// (R13) Output enable hands pin to compare a
// (R14) Software orders setup: compare, control one, two
// (R15) Counter advances once per prescaled tick
`timescale 1ns/10ps
module tmr_one_pulse
    import tmr_pkg::*;
#(
    parameter int SLOW_PRESCALE = 8000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic trigger_input_a,
    input wire logic capture_input_b,
    output logic pulse_output_a,
    output logic pulse_output_a_oe,
    output logic irq
);
    tmr_state_type q;
    tmr_state_type n;

    logic single;
    logic stable_a;
    logic stable_b;
    logic ev_a;
    logic ev_b;
    logic tick;
    logic trig;
    logic match_a;
    logic match_b;
    logic ovf_ev;
    logic cap_a_set;
    logic cmp_a_set;
    logic [7:0] cnt_next;
    logic [PRESC_W-1:0] div;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irq_clr;
    logic wr_ctl1;
    logic stat_rd;
    logic acc_cap_a;
    logic acc_cap_b;
    logic acc_cmp_a;
    logic acc_cmp_b;
    logic rd_cnt;

    // ------------------------------------------------------------------
    // Decode and mode
    // ------------------------------------------------------------------
    // PWM wins over single shot
    assign single = q.ctl2[C2_SINGLE] & ~q.ctl2[C2_PWM]; // R1 R8
    assign stat_rd = reg_read && reg_addr == ADDR_STATUS;
    // Capture and compare clears accept reads and writes alike
    assign acc_cap_a = (reg_read || reg_write) && reg_addr == ADDR_CAP_A;
    assign acc_cap_b = (reg_read || reg_write) && reg_addr == ADDR_CAP_B;
    assign acc_cmp_a = (reg_read || reg_write) && reg_addr == ADDR_CMP_A;
    assign acc_cmp_b = (reg_read || reg_write) && reg_addr == ADDR_CMP_B;
    assign rd_cnt = reg_read && reg_addr == ADDR_CNT;
    assign wr_ctl1 = reg_write && reg_addr == ADDR_CTRL_ONE;

    // ------------------------------------------------------------------
    // Input filtering
    // ------------------------------------------------------------------
    // Stages 1 and 2 must agree before a level change counts
    assign stable_a = q.sync_a[1] == q.sync_a[2];
    assign stable_b = q.sync_b[1] == q.sync_b[2];
    assign ev_a = stable_a && q.sync_a[2] != q.filt_a
        && q.sync_a[2] == q.ctl1[C1_EDGE_A]; // R12
    assign ev_b = stable_b && q.sync_b[2] != q.filt_b
        && q.sync_b[2] == q.ctl2[C2_EDGE_B];

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    always_comb begin
        unique case (q.ctl2[C2_PRESC_HI:C2_PRESC_LO])
            2'h0: div = PRESC_DIV2;
            2'h1: div = PRESC_DIV4;
            2'h2: div = PRESC_DIV8;
            2'h3: div = PRESC_W'(SLOW_PRESCALE);
        endcase
    end

    assign tick = q.presc >= div - PRESC_ONE;
    assign trig = single && ev_a; // R2 R10

    always_comb begin
        cnt_next = q.cnt;
        if (trig) begin
            cnt_next = TRIG_PRESET; // R2
        end else if (tick) begin
            cnt_next = q.cnt + 8'h01; // R15
        end
    end

    assign ovf_ev = tick && !trig && q.cnt == CNT_LAST;
    assign match_a = tick && !trig && cnt_next == q.cmp_a;
    assign match_b = tick && !trig && cnt_next == q.cmp_b;
    // Ordinary capture on input a only outside pulse mode
    assign cap_a_set = trig || (ev_a && !single); // R10
    assign cmp_a_set = match_a && !single; // R7
    assign events = {ovf_ev, match_b, ev_b, cap_a_set};
    assign irq_clr = (reg_write && reg_addr == ADDR_IRQ_CLEAR)
        ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        n.sync_a = {q.sync_a[1:0], trigger_input_a};
        n.sync_b = {q.sync_b[1:0], capture_input_b};
        if (stable_a) begin
            n.filt_a = q.sync_a[2];
        end
        if (stable_b) begin
            n.filt_b = q.sync_b[2];
        end
        // A trigger also restarts the prescaler for an exact width
        n.presc = (tick || trig) ? PRESC_ZERO : q.presc + PRESC_ONE;
        n.cnt = cnt_next;

        // Pulse level: trigger first, then the compare match
        if (trig) begin
            n.out_a = q.ctl1[C1_DURING]; // R2
        end else if (match_a && !q.ctl2[C2_PWM]) begin
            n.out_a = q.ctl1[C1_AFTER]; // R5 R9
        end else if (wr_ctl1 && reg_wdata[C1_FORCE_A] && !single) begin
            n.out_a = reg_wdata[C1_AFTER];
        end

        if (trig) begin
            n.cap_a = TRIG_CAPTURE[7:0]; // R2
        end else if (cap_a_set) begin
            n.cap_a = q.cnt;
        end
        if (ev_b) begin
            n.cap_b = q.cnt; // R10
        end

        // Arming follows each status read
        if (stat_rd) begin
            n.arm_cap_a = q.cap_a_f;
            n.arm_cmp_a = q.cmp_a_f;
            n.arm_ovf = q.ovf_f;
            n.arm_cap_b = q.cap_b_f;
            n.arm_cmp_b = q.cmp_b_f;
        end
        if (acc_cap_a) begin
            n.arm_cap_a = 1'b0;
        end
        if (acc_cap_b) begin
            n.arm_cap_b = 1'b0;
        end
        if (acc_cmp_a) begin
            n.arm_cmp_a = 1'b0;
        end
        if (acc_cmp_b) begin
            n.arm_cmp_b = 1'b0;
        end
        if (rd_cnt) begin
            n.arm_ovf = 1'b0;
        end

        // Set wins over a clear in the same cycle
        n.cap_a_f = cap_a_set
            || (q.cap_a_f && !(acc_cap_a && q.arm_cap_a)); // R4
        n.cap_b_f = ev_b
            || (q.cap_b_f && !(acc_cap_b && q.arm_cap_b)); // R4 R10
        n.cmp_a_f = cmp_a_set
            || (q.cmp_a_f && !(acc_cmp_a && q.arm_cmp_a)); // R7
        n.cmp_b_f = match_b
            || (q.cmp_b_f && !(acc_cmp_b && q.arm_cmp_b)); // R11
        n.ovf_f = ovf_ev || (q.ovf_f && !(rd_cnt && q.arm_ovf));

        n.irq_st = events | (q.irq_st & ~irq_clr);

        if (reg_write) begin
            unique case (reg_addr)
                ADDR_CTRL_TWO: n.ctl2 = reg_wdata & CTRL_TWO_MASK;
                ADDR_CTRL_ONE: n.ctl1 = reg_wdata;
                ADDR_CMP_A: n.cmp_a = reg_wdata;
                ADDR_CMP_B: n.cmp_b = reg_wdata;
                ADDR_IRQ_ENABLE: n.irq_en = reg_wdata[IRQ_W-1:0];
                default: n.rdata = q.rdata;
            endcase
        end

        // Read data stands only in the cycle after the strobe
        n.rdata = RESET_BYTE;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_CTRL_TWO: n.rdata = q.ctl2 & CTRL_TWO_MASK;
                ADDR_CTRL_ONE: n.rdata = q.ctl1;
                ADDR_STATUS: n.rdata = {q.cap_a_f, q.cmp_a_f, q.ovf_f,
                    q.cap_b_f, q.cmp_b_f, 3'h0};
                ADDR_CAP_A: n.rdata = q.cap_a;
                ADDR_CMP_A: n.rdata = q.cmp_a;
                ADDR_CNT: n.rdata = q.cnt;
                ADDR_ALT_CNT: n.rdata = q.cnt;
                ADDR_CAP_B: n.rdata = q.cap_b;
                ADDR_CMP_B: n.rdata = q.cmp_b;
                ADDR_IRQ_STATUS: n.rdata = {4'h0, q.irq_st};
                ADDR_IRQ_ENABLE: n.rdata = {4'h0, q.irq_en};
                default: n.rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = q.rdata;
    assign pulse_output_a = q.out_a;
    assign pulse_output_a_oe = q.ctl2[C2_OUT_EN]; // R13
    assign irq = (|(q.irq_st & q.irq_en))
        || (q.ctl1[C1_CAP_IE] && (q.cap_a_f || q.cap_b_f)) // R3
        || (q.ctl1[C1_CMP_IE] && (q.cmp_a_f || q.cmp_b_f)) // R11
        || (q.ctl1[C1_OVF_IE] && q.ovf_f);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_stat_rd_a;
        stat_rd && q.cap_a_f;
    endsequence

    sequence s_low_access_a;
        acc_cap_a && !cap_a_set;
    endsequence

    a_mode_gate: assert property ( // R1
        ev_a && !q.ctl2[C2_SINGLE] && !tick |=> q.cnt == $past(q.cnt))
        else $error("counter moved on trigger outside pulse mode");

    a_trig_preset: assert property ( // R2
        trig |=> q.cnt == TRIG_PRESET
            && q.out_a == $past(q.ctl1[C1_DURING]))
        else $error("trigger did not preset counter and level");

    a_trig_capture: assert property ( // R2
        trig |=> q.cap_a == TRIG_CAPTURE[7:0] && q.cap_a_f)
        else $error("trigger did not load capture marker");

    a_cap_irq_req: assert property ( // R3
        trig && q.ctl1[C1_CAP_IE] |=> irq)
        else $error("capture interrupt missing");

    a_flag_clear_seq: assert property ( // R4
        s_stat_rd_a ##[1:2] s_low_access_a |=> !q.cap_a_f)
        else $error("capture flag not cleared by sequence");

    a_flag_hold: assert property ( // R4
        q.cap_a_f && !acc_cap_a |=> q.cap_a_f)
        else $error("capture flag lost without access");

    a_after_level: assert property ( // R5
        single && match_a |=> q.out_a == $past(q.ctl1[C1_AFTER]))
        else $error("after-pulse level not driven on match");

    a_no_cmp_flag: assert property ( // R7
        $rose(q.cmp_a_f) |-> !$past(single))
        else $error("compare flag a set in pulse mode");

    a_pwm_priority: assert property ( // R8
        q.ctl2[C2_PWM] && q.ctl2[C2_SINGLE] && ev_a && !tick
            |=> q.cnt == $past(q.cnt))
        else $error("pulse mode active under PWM select");

    a_const_level: assert property ( // R9
        single && q.ctl1[C1_AFTER] == q.ctl1[C1_DURING]
            && q.out_a == q.ctl1[C1_AFTER] && !wr_ctl1
            |=> $stable(q.out_a))
        else $error("output moved with equal levels");

    a_cap_b_live: assert property ( // R10
        ev_b |=> q.cap_b_f && q.cap_b == $past(q.cnt))
        else $error("capture b not taken");

    a_cmp_b_flag: assert property ( // R11
        match_b |=> q.cmp_b_f)
        else $error("compare b flag not set");

    a_count_step: assert property ( // R15
        tick && !trig |=> q.cnt == 8'($past(q.cnt) + 8'h01))
        else $error("counter did not advance on tick");

    // ------------------------------------------------------------------
    // Bus and interrupt checks
    // ------------------------------------------------------------------
    // A stale byte on the read port would be taken by the next read
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == RESET_BYTE)
        else $error("read data not zero outside read cycle");

    a_rdata_value: assert property (
        reg_read && reg_addr == ADDR_CMP_A |=> reg_rdata == $past(q.cmp_a))
        else $error("compare a read back wrong");

    a_oe_rise: assert property ( // R13
        $rose(pulse_output_a_oe) |-> $past(reg_write
            && reg_addr == ADDR_CTRL_TWO && reg_wdata[C2_OUT_EN]))
        else $error("pin handed over without control write");

    a_irq_cap: assert property ( // R3
        q.ctl1[C1_CAP_IE] && q.cap_a_f |-> irq)
        else $error("capture flag a without interrupt");

    a_irq_cmp_b: assert property ( // R11
        q.ctl1[C1_CMP_IE] && q.cmp_b_f |-> irq)
        else $error("compare flag b without interrupt");

    a_irq_ovf: assert property (
        q.ctl1[C1_OVF_IE] && q.ovf_f |-> irq)
        else $error("overflow flag without interrupt");

    // Only the armed access may drop the flag
    a_cap_clear_arm: assert property ( // R4
        $fell(q.cap_a_f) |-> $past(acc_cap_a && q.arm_cap_a))
        else $error("capture flag a dropped without sequence");

    a_pwm_no_trig: assert property ( // R8
        q.ctl2[C2_PWM] |-> !trig)
        else $error("trigger taken under PWM select");

    a_plain_capture: assert property ( // R10
        cap_a_set && !single |=> q.cap_a == $past(q.cnt))
        else $error("ordinary capture a not taken");

    a_cap_b_latch: assert property ( // R10
        ev_b |=> q.irq_st[IRQ_CAP_B])
        else $error("capture b event not latched");

    // Compare b must never reach the pin while a pulse is in use
    a_cmp_b_quiet: assert property ( // R11
        single && match_b && !match_a |=> $stable(q.out_a))
        else $error("compare b moved the pulse output");

    a_tick_gap: assert property ( // R15
        tick |=> !tick)
        else $error("prescaler ticked twice in a row");

    a_ovf_flag: assert property (
        ovf_ev |=> q.ovf_f)
        else $error("overflow flag not set");
endmodule : tmr_one_pulse

// File: rtl/tmr_pkg.sv
// Package: register map, field positions and state of the one-pulse timer
package tmr_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h3c;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h3d;
    localparam logic [7:0] ADDR_STATUS = 8'h3e;
    localparam logic [7:0] ADDR_CAP_A = 8'h3f;
    localparam logic [7:0] ADDR_CMP_A = 8'h40;
    localparam logic [7:0] ADDR_CNT = 8'h41;
    localparam logic [7:0] ADDR_ALT_CNT = 8'h42;
    localparam logic [7:0] ADDR_CAP_B = 8'h43;
    localparam logic [7:0] ADDR_CMP_B = 8'h44;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h45;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h46;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h47;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int C2_OUT_EN = 7;
    localparam int C2_SINGLE = 5;
    localparam int C2_PWM = 4;
    localparam int C2_PRESC_HI = 3;
    localparam int C2_PRESC_LO = 2;
    localparam int C2_EDGE_B = 1;
    localparam int C1_CAP_IE = 7;
    localparam int C1_CMP_IE = 6;
    localparam int C1_OVF_IE = 5;
    localparam int C1_FORCE_A = 3;
    localparam int C1_DURING = 2;
    localparam int C1_EDGE_A = 1;
    localparam int C1_AFTER = 0;
    localparam int IRQ_CAP_A = 0;
    localparam int IRQ_CAP_B = 1;
    localparam int IRQ_CMP_B = 2;
    localparam int IRQ_OVF = 3;
    localparam int IRQ_W = 4;
    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_TWO_MASK = 8'hfe;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CNT_LAST = 8'hff;
    localparam logic [7:0] TRIG_PRESET = 8'hfc;
    localparam logic [15:0] TRIG_CAPTURE = 16'hfffd;
    localparam int PRESC_W = 13;
    localparam logic [PRESC_W-1:0] PRESC_DIV2 = 13'h0002;
    localparam logic [PRESC_W-1:0] PRESC_DIV4 = 13'h0004;
    localparam logic [PRESC_W-1:0] PRESC_DIV8 = 13'h0008;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 13'h0001;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 13'h0000;

    typedef struct packed {
        logic [7:0] ctl2;
        logic [7:0] ctl1;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] cnt;
        logic [7:0] cap_a;
        logic [7:0] cap_b;
        logic [PRESC_W-1:0] presc;
        logic cap_a_f;
        logic cmp_a_f;
        logic ovf_f;
        logic cap_b_f;
        logic cmp_b_f;
        logic arm_cap_a;
        logic arm_cmp_a;
        logic arm_ovf;
        logic arm_cap_b;
        logic arm_cmp_b;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic filt_a;
        logic filt_b;
        logic out_a;
        logic [7:0] rdata;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
    } tmr_state_type;
endpackage : tmr_pkg
